// [verilog/cec_pkg.sv]
`default_nettype none

package cec_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  localparam int CNT_NUM = 2;
  localparam int SRC_W = 4;
  localparam int MODE_W = 2;
  localparam int NUM_SRC = 16;
  localparam int NUM_IRQ = 9;
  localparam int LANES = 4;

  // Byte addresses of the register words
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG [CNT_NUM] = '{8'h08, 8'h04};
  localparam logic [ADDR_W-1:0] OFS_VAL [CNT_NUM] = '{8'h10, 8'h0C};
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MSTAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RAW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_AUX = 8'h24;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT [CNT_NUM] = '{1, 2};
  localparam int CFG_SRC_LSB = 2;
  localparam int CFG_SRC_MSB = 5;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_MSB = 1;
  localparam int AUX_NS_INT_BIT = 27;

  localparam logic [SRC_W-1:0] SRC_DISABLED = 4'h0;
  localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_INCR = 2'h1;
  localparam logic [MODE_W-1:0] MODE_OVFL = 2'h2;

  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0] CNT_NEAR_MAX = 32'hFFFFFFFE;
  localparam logic [NUM_IRQ-1:0] MASK_RESET = 9'h000;
  localparam logic AUX_NS_INT_RESET = 1'b0;

  localparam int IRQ_CNT_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : cec_pkg

`default_nettype wire

// [verilog/cec_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module cec_counter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [cec_pkg::NUM_SRC-1:0] i_evt,
  input wire logic [cec_pkg::NUM_SRC-1:0] i_evt_secure,
  input wire logic i_debug_en,
  input wire logic i_count_en,
  input wire logic [cec_pkg::SRC_W-1:0] i_src,
  input wire logic [cec_pkg::MODE_W-1:0] i_mode,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [cec_pkg::CNT_W-1:0] i_load_data,
  output logic [cec_pkg::CNT_W-1:0] o_value,
  output logic o_irq
);
  import cec_pkg::*;

  logic hit;
  logic step;

  assign hit = i_count_en && (i_src != SRC_DISABLED) && i_evt[i_src] &&
               (!i_evt_secure[i_src] || i_debug_en);
  assign step = hit && (o_value != CNT_MAX);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_value <= CNT_RESET;
    end else if (i_clear) begin
      o_value <= CNT_RESET;
    end else if (i_load) begin
      o_value <= i_load_data;
    end else if (step) begin
      o_value <= o_value + 32'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= step && !i_clear && !i_load &&
               ((i_mode == MODE_INCR) ||
                ((i_mode == MODE_OVFL) && (o_value == CNT_NEAR_MAX)));
    end
  end
endmodule : cec_counter

`default_nettype wire

// [verilog/cec_irq.sv]
`timescale 1ns/1ps
`default_nettype none

module cec_irq (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [cec_pkg::NUM_IRQ-1:0] i_set,
  input wire logic [cec_pkg::NUM_IRQ-1:0] i_clear,
  input wire logic [cec_pkg::NUM_IRQ-1:0] i_mask,
  output logic [cec_pkg::NUM_IRQ-1:0] o_raw,
  output logic [cec_pkg::NUM_IRQ-1:0] o_lines,
  output logic o_any
);
  import cec_pkg::*;

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_raw <= '0;
    end else begin
      o_raw <= (o_raw & ~i_clear) | i_set;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lines <= '0;
      o_any <= 1'b0;
    end else begin
      o_lines <= o_raw & i_mask;
      o_any <= |(o_raw & i_mask);
    end
  end
endmodule : cec_irq

`default_nettype wire

// [verilog/cec_top.sv]
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module cec_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [cec_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [cec_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [cec_pkg::LANES-1:0] i_avs_byteenable,
  input wire logic i_avs_nonsecure,
  output logic [cec_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_secure_noninvasive_debug_en,
  input wire logic i_evt_castout,
  input wire logic i_evt_data_read_hit,
  input wire logic i_evt_data_read_request,
  input wire logic i_evt_data_write_hit,
  input wire logic i_evt_data_write_request,
  input wire logic i_evt_data_writethrough_request,
  input wire logic i_evt_instr_read_hit,
  input wire logic i_evt_instr_read_request,
  input wire logic i_evt_write_allocate,
  input wire logic i_evt_internal_prefetch_alloc,
  input wire logic i_evt_external_prefetch_hit,
  input wire logic i_evt_external_prefetch_alloc,
  input wire logic i_evt_spec_read_received,
  input wire logic i_evt_spec_read_confirmed,
  input wire logic i_evt_external_prefetch_received,
  input wire logic [cec_pkg::NUM_SRC-1:0] i_evt_secure,
  input wire logic i_next_level_decode_error_src,
  input wire logic i_next_level_slave_error_src,
  input wire logic i_data_ram_read_error_src,
  input wire logic i_tag_ram_read_error_src,
  input wire logic i_data_ram_write_error_src,
  input wire logic i_tag_ram_write_error_src,
  input wire logic i_data_ram_read_parity_error_src,
  input wire logic i_tag_ram_read_parity_error_src,
  output logic o_next_level_decode_error,
  output logic o_next_level_slave_error,
  output logic o_data_ram_read_error,
  output logic o_tag_ram_read_error,
  output logic o_data_ram_write_error,
  output logic o_tag_ram_write_error,
  output logic o_data_ram_read_parity_error,
  output logic o_tag_ram_read_parity_error,
  output logic o_counter_overflow_increment_irq,
  output logic o_combined_interrupt_out
);
  import cec_pkg::*;

  typedef enum {BUS_IDLE, BUS_ANSWER} cec_bus_state_t;

  cec_bus_state_t bus_state_reg;
  logic dbg_meta_reg;
  logic dbg_sync_reg;
  logic ctrl_en_reg;
  logic aux_ns_int_reg;
  logic [NUM_IRQ-1:0] mask_reg;
  logic [SRC_W-1:0] cfg_src_reg [CNT_NUM];
  logic [MODE_W-1:0] cfg_mode_reg [CNT_NUM];
  logic [CNT_W-1:0] cnt_value [CNT_NUM];
  logic [CNT_NUM-1:0] cnt_clear;
  logic [CNT_NUM-1:0] cnt_load;
  logic [CNT_NUM-1:0] cnt_irq;
  logic [CNT_NUM-1:0] cnt_hit;
  logic [NUM_IRQ-1:0] irq_raw;
  logic [NUM_IRQ-1:0] irq_set;
  logic [NUM_IRQ-1:0] irq_clear;
  logic [NUM_IRQ-1:0] irq_lines;
  logic [NUM_IRQ-1:0] irq_masked;
  logic [NUM_SRC-1:0] evt_vec;
  logic [DATA_W-1:0] rdata_cmb;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wdata_eff;
  logic [1:0] resp_cmb;
  logic mapped;
  logic req;
  logic commit;

  // Code 0 is the disabled slot, never an event
  assign evt_vec = {i_evt_external_prefetch_received, i_evt_spec_read_confirmed,
                    i_evt_spec_read_received, i_evt_external_prefetch_alloc,
                    i_evt_external_prefetch_hit, i_evt_internal_prefetch_alloc,
                    i_evt_write_allocate, i_evt_instr_read_request,
                    i_evt_instr_read_hit, i_evt_data_writethrough_request,
                    i_evt_data_write_request, i_evt_data_write_hit,
                    i_evt_data_read_request, i_evt_data_read_hit,
                    i_evt_castout, 1'b0};

  assign req = i_avs_read || i_avs_write;
  // Writes land on the edge the master sees waitrequest low
  assign commit = (bus_state_reg == BUS_ANSWER) && i_avs_write &&
                  (o_avs_response == RESP_OKAY);

  for (genvar b = 0; b < LANES; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{i_avs_byteenable[b]}};
  end
  // Disabled lanes keep the current readable contents of CTRL, CFG, MASK and AUX; VAL loads and CLEAR take every lane
  assign wdata_eff = (i_avs_writedata & wmask) | (rdata_cmb & ~wmask);

  // Debug enable is a pin, so synchronise it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dbg_meta_reg <= 1'b0;
      dbg_sync_reg <= 1'b0;
    end else begin
      dbg_meta_reg <= i_secure_noninvasive_debug_en;
      dbg_sync_reg <= dbg_meta_reg;
    end
  end

  always_comb begin
    rdata_cmb = '0;
    case (i_avs_address)
      OFS_CTRL: rdata_cmb[CTRL_EN_BIT] = ctrl_en_reg;
      OFS_CFG[0]: rdata_cmb[CFG_SRC_MSB:CFG_MODE_LSB] = {cfg_src_reg[0], cfg_mode_reg[0]};
      OFS_CFG[1]: rdata_cmb[CFG_SRC_MSB:CFG_MODE_LSB] = {cfg_src_reg[1], cfg_mode_reg[1]};
      OFS_VAL[0]: rdata_cmb = cnt_value[0];
      OFS_VAL[1]: rdata_cmb = cnt_value[1];
      OFS_MASK: rdata_cmb[NUM_IRQ-1:0] = mask_reg;
      OFS_MSTAT: rdata_cmb[NUM_IRQ-1:0] = irq_masked;
      OFS_RAW: rdata_cmb[NUM_IRQ-1:0] = irq_raw;
      OFS_AUX: rdata_cmb[AUX_NS_INT_BIT] = aux_ns_int_reg;
      default: rdata_cmb = '0;
    endcase
  end

  always_comb begin
    mapped = 1'b0;
    case (i_avs_address)
      OFS_CTRL, OFS_CFG[0], OFS_CFG[1], OFS_VAL[0], OFS_VAL[1],
      OFS_MASK, OFS_MSTAT, OFS_RAW, OFS_CLEAR, OFS_AUX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    resp_cmb = mapped ? RESP_OKAY : RESP_DECERR;
    if (i_avs_write && i_avs_nonsecure && !aux_ns_int_reg &&
        ((i_avs_address == OFS_MASK) || (i_avs_address == OFS_CLEAR) ||
         (i_avs_address == OFS_AUX))) begin
      resp_cmb = RESP_DECERR;
    end
  end

  // One wait cycle, then one answer cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_state_reg <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
      o_avs_response <= RESP_OKAY;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= BUS_ANSWER;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= i_avs_read ? rdata_cmb : '0;
            o_avs_response <= resp_cmb;
          end
        end
        BUS_ANSWER: begin
          bus_state_reg <= BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_en_reg <= 1'b0;
    end else if (commit && (i_avs_address == OFS_CTRL)) begin
      ctrl_en_reg <= wdata_eff[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_reg <= MASK_RESET;
    end else if (commit && (i_avs_address == OFS_MASK)) begin
      mask_reg <= wdata_eff[NUM_IRQ-1:0];
    end
  end

  // Aux bit 27 lets non-secure writes reach interrupt registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aux_ns_int_reg <= AUX_NS_INT_RESET;
    end else if (commit && (i_avs_address == OFS_AUX)) begin
      aux_ns_int_reg <= wdata_eff[AUX_NS_INT_BIT];
    end
  end

  assign irq_clear = (commit && (i_avs_address == OFS_CLEAR)) ?
                     i_avs_writedata[NUM_IRQ-1:0] : '0;
  assign irq_set = {i_next_level_decode_error_src, i_next_level_slave_error_src,
                    i_data_ram_read_error_src, i_tag_ram_read_error_src,
                    i_data_ram_write_error_src, i_tag_ram_write_error_src,
                    i_data_ram_read_parity_error_src, i_tag_ram_read_parity_error_src,
                    |cnt_irq};
  assign irq_masked = irq_raw & mask_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  for (genvar g = 0; g < CNT_NUM; g++) begin : g_cnt
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cfg_src_reg[g] <= SRC_DISABLED;
        cfg_mode_reg[g] <= MODE_OFF;
      end else if (commit && (i_avs_address == OFS_CFG[g])) begin
        cfg_src_reg[g] <= wdata_eff[CFG_SRC_MSB:CFG_SRC_LSB];
        cfg_mode_reg[g] <= wdata_eff[CFG_MODE_MSB:CFG_MODE_LSB];
      end
    end

    assign cnt_clear[g] = commit && (i_avs_address == OFS_CTRL) &&
                          wdata_eff[CTRL_RST_BIT[g]];
    assign cnt_load[g] = commit && (i_avs_address == OFS_VAL[g]) &&
                         (cfg_src_reg[g] == SRC_DISABLED);
    assign cnt_hit[g] = ctrl_en_reg && (cfg_src_reg[g] != SRC_DISABLED) &&
                        evt_vec[cfg_src_reg[g]] &&
                        (!i_evt_secure[cfg_src_reg[g]] || dbg_sync_reg);

    cec_counter u_counter (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_evt(evt_vec),
      .i_evt_secure(i_evt_secure),
      .i_debug_en(dbg_sync_reg),
      .i_count_en(ctrl_en_reg),
      .i_src(cfg_src_reg[g]),
      .i_mode(cfg_mode_reg[g]),
      .i_clear(cnt_clear[g]),
      .i_load(cnt_load[g]),
      .i_load_data(i_avs_writedata),
      .o_value(cnt_value[g]),
      .o_irq(cnt_irq[g])
    );

    AST_COUNT_STEP:
      assert property (cnt_hit[g] && (cnt_value[g] != CNT_MAX) && !cnt_clear[g] &&
                       !cnt_load[g] |=> cnt_value[g] == $past(cnt_value[g]) + 32'h1)
      else $error("Counter missed a selected event");
    AST_INCR_IRQ:
      assert property (cnt_hit[g] && (cnt_value[g] != CNT_MAX) && !cnt_clear[g] &&
                       !cnt_load[g] && (cfg_mode_reg[g] == MODE_INCR)
                       |=> cnt_irq[g] ##1 irq_raw[IRQ_CNT_BIT])
      else $error("Increment interrupt not raised");
    AST_SECURE_BLOCK:
      assert property (!dbg_sync_reg && i_evt_secure[cfg_src_reg[g]] && !cnt_clear[g] &&
                       !cnt_load[g] |=> $stable(cnt_value[g]))
      else $error("Secure event counted without debug enable");
    AST_SATURATE:
      assert property ((cnt_value[g] == CNT_MAX) && !cnt_clear[g] && !cnt_load[g]
                       |=> cnt_value[g] == CNT_MAX)
      else $error("Counter wrapped past maximum");
    AST_PRELOAD_REFUSED:
      assert property (commit && (i_avs_address == OFS_VAL[g]) &&
                       (cfg_src_reg[g] != SRC_DISABLED) && !cnt_clear[g]
                       |=> (cnt_value[g] == $past(cnt_value[g])) ||
                           (cnt_value[g] == $past(cnt_value[g]) + 32'h1))
      else $error("Preload accepted while counting source set");
    AST_COUNTER_RESET:
      assert property (cnt_clear[g] |=> cnt_value[g] == CNT_RESET)
      else $error("Counter reset bit did not clear value");
  end

  cec_irq u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(irq_set),
    .i_clear(irq_clear),
    .i_mask(mask_reg),
    .o_raw(irq_raw),
    .o_lines(irq_lines),
    .o_any(o_combined_interrupt_out)
  );

  assign {o_next_level_decode_error, o_next_level_slave_error, o_data_ram_read_error,
          o_tag_ram_read_error, o_data_ram_write_error, o_tag_ram_write_error,
          o_data_ram_read_parity_error, o_tag_ram_read_parity_error,
          o_counter_overflow_increment_irq} = irq_lines;

  sequence s_req_taken;
    (bus_state_reg == BUS_IDLE) && req;
  endsequence
  sequence s_answer_once;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  sequence s_ns_mask_write;
    (bus_state_reg == BUS_IDLE) && i_avs_write && i_avs_nonsecure && !aux_ns_int_reg &&
    (i_avs_address == OFS_MASK);
  endsequence
  sequence s_mask_read;
    (bus_state_reg == BUS_IDLE) && i_avs_read && (i_avs_address == OFS_MASK);
  endsequence

  AST_BUS_ANSWER:
    assert property (s_req_taken |=> s_answer_once)
    else $error("Bus answer not one cycle after request");
  AST_MASK_NS_REFUSED:
    assert property (s_ns_mask_write |=> (o_avs_response == RESP_DECERR) ##1 $stable(mask_reg))
    else $error("Non-secure mask write not refused");
  AST_MASKED_READ:
    assert property ((bus_state_reg == BUS_IDLE) && i_avs_read &&
                     (i_avs_address == OFS_MSTAT)
                     |=> o_avs_readdata[NUM_IRQ-1:0] == $past(irq_masked))
    else $error("Masked status read differs from raw and mask");
  AST_MASK_RESERVED:
    assert property (s_mask_read |=> o_avs_readdata[DATA_W-1:NUM_IRQ] == '0)
    else $error("Reserved mask bits read nonzero");
  AST_MASK_BLOCKS:
    assert property (!(|irq_masked) |=> !o_combined_interrupt_out &&
                     !o_counter_overflow_increment_irq)
    else $error("Masked source reached an interrupt output");
  AST_MASK_PASSES:
    assert property (irq_masked[IRQ_CNT_BIT] |=> o_combined_interrupt_out &&
                     o_counter_overflow_increment_irq)
    else $error("Enabled source did not reach outputs");
endmodule : cec_top

`default_nettype wire

// [sim/cec_evt_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Cache-side event source; idle lines sit low between pulses
module cec_evt_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fire,
  input wire logic [cec_pkg::SRC_W-1:0] i_code,
  output logic [cec_pkg::NUM_SRC-1:0] o_evt
);
  import cec_pkg::*;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_evt <= '0;
    end else begin
      o_evt <= i_fire ? (NUM_SRC'(1) << i_code) : '0;
    end
  end
endmodule : cec_evt_model

`default_nettype wire

// [sim/test_cache_event_counters_irq_mask.sv]
`timescale 1ns/1ps
`default_nettype none

module test_cache_event_counters_irq_mask;
  import cec_pkg::*;
  logic i_clk;
  logic i_rst;
  logic [7:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [3:0] be;
  logic ns;
  logic dbg;
  logic fire;
  logic [3:0] code;
  logic [15:0] sec;
  logic [8:1] err;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] resp;
  logic [15:0] evt;
  logic [8:0] irq;
  logic comb;
  logic [31:0] rdv;
  logic [1:0] rsp;
  int n_mismatch;
  int comparisons;
  int cyc;

  cec_top u_cec_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .i_avs_nonsecure(ns), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .o_avs_response(resp), .i_secure_noninvasive_debug_en(dbg),
    .i_evt_castout(evt[1]), .i_evt_data_read_hit(evt[2]),
    .i_evt_data_read_request(evt[3]), .i_evt_data_write_hit(evt[4]),
    .i_evt_data_write_request(evt[5]), .i_evt_data_writethrough_request(evt[6]),
    .i_evt_instr_read_hit(evt[7]), .i_evt_instr_read_request(evt[8]),
    .i_evt_write_allocate(evt[9]), .i_evt_internal_prefetch_alloc(evt[10]),
    .i_evt_external_prefetch_hit(evt[11]), .i_evt_external_prefetch_alloc(evt[12]),
    .i_evt_spec_read_received(evt[13]), .i_evt_spec_read_confirmed(evt[14]),
    .i_evt_external_prefetch_received(evt[15]), .i_evt_secure(sec),
    .i_next_level_decode_error_src(err[8]), .i_next_level_slave_error_src(err[7]),
    .i_data_ram_read_error_src(err[6]), .i_tag_ram_read_error_src(err[5]),
    .i_data_ram_write_error_src(err[4]), .i_tag_ram_write_error_src(err[3]),
    .i_data_ram_read_parity_error_src(err[2]), .i_tag_ram_read_parity_error_src(err[1]),
    .o_next_level_decode_error(irq[8]), .o_next_level_slave_error(irq[7]),
    .o_data_ram_read_error(irq[6]), .o_tag_ram_read_error(irq[5]),
    .o_data_ram_write_error(irq[4]), .o_tag_ram_write_error(irq[3]),
    .o_data_ram_read_parity_error(irq[2]), .o_tag_ram_read_parity_error(irq[1]),
    .o_counter_overflow_increment_irq(irq[0]), .o_combined_interrupt_out(comb)
  );

  cec_evt_model u_cec_evt_model (
    .i_clk(i_clk), .i_rst(i_rst), .i_fire(fire), .i_code(code), .o_evt(evt)
  );

  always #5 i_clk = ~i_clk;

  task close_out;
    $display("counts: mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Slave latency is not assumed; only the hang guard ends a wait
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    ns <= s;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge i_clk);
    end while (wreq !== 1'b0);
    rdv = rdata;
    rsp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    // Answer stands one cycle only
    @(posedge i_clk);
    chk("bus answer one cycle", 32'h1, 32'(wreq));
  endtask : acc

  task wrr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask : wrr

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 1'b0);
    chk(nm, e, rdv);
  endtask : rdc

  task pulse(input logic [3:0] c, input int k);
    repeat (k) begin
      @(posedge i_clk);
      fire <= 1'b1;
      code <= c;
    end
    @(posedge i_clk);
    fire <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse

  task perr(input logic [8:1] v);
    @(posedge i_clk);
    err <= v;
    @(posedge i_clk);
    err <= 8'h00;
    repeat (3) @(posedge i_clk);
  endtask : perr

  task t_reset;
    rdc("mask", OFS_MASK, 32'h0);
    rdc("ctrl", OFS_CTRL, 32'h0);
    rdc("value0", OFS_VAL[0], 32'h0);
    acc(1'b0, 8'h40, 32'h0, 1'b0);
    chk("unmapped resp", 32'h3, 32'(rsp));
    wrr(OFS_CFG[0], 32'hFFFFFFFF);
    rdc("cfg0", OFS_CFG[0], 32'h0000003F);
    pulse(4'hF, 1);
    rdc("value0 enable off", OFS_VAL[0], 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task t_codes;
    for (int c = 1; c < 16; c++) begin
      wrr(OFS_CFG[0], 32'((c << 2) | 1));
      wrr(OFS_CTRL, 32'h3);
      pulse(4'(c), 2);
      pulse(4'((c % 15) + 1), 1);
      rdc("value0 per code", OFS_VAL[0], 32'h2);
    end
    rdc("ctrl", OFS_CTRL, 32'h1);
    rdc("raw incr", OFS_RAW, 32'h1);
    wrr(OFS_CFG[0], 32'h0000000B);
    wrr(OFS_CLEAR, 32'h1FF);
    pulse(4'h2, 1);
    rdc("raw mode 11", OFS_RAW, 32'h0);
    $display("t_codes done");
  endtask : t_codes

  task t_secure;
    wrr(OFS_CFG[1], 32'h00000014);
    wrr(OFS_CTRL, 32'h5);
    @(posedge i_clk);
    sec <= 16'h0020;
    pulse(4'h5, 2);
    rdc("value1 secure off", OFS_VAL[1], 32'h0);
    dbg <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(4'h5, 2);
    rdc("value1 secure on", OFS_VAL[1], 32'h2);
    rdc("raw mode 00", OFS_RAW, 32'h0);
    sec <= 16'h0000;
    dbg <= 1'b0;
    $display("t_secure done");
  endtask : t_secure

  task t_preload;
    wrr(OFS_CTRL, 32'h3);
    wrr(OFS_VAL[0], 32'h00000055);
    rdc("value0 locked", OFS_VAL[0], 32'h0);
    wrr(OFS_CFG[0], 32'h0);
    wrr(OFS_VAL[0], 32'hFFFFFFFD);
    rdc("value0 preload", OFS_VAL[0], 32'hFFFFFFFD);
    wrr(OFS_CFG[0], 32'h0000000A);
    wrr(OFS_CLEAR, 32'h1FF);
    pulse(4'h2, 1);
    rdc("raw before ovf", OFS_RAW, 32'h0);
    wrr(OFS_MASK, 32'h1);
    pulse(4'h2, 1);
    rdc("value0 max", OFS_VAL[0], CNT_MAX);
    rdc("raw ovf", OFS_RAW, 32'h1);
    chk("cnt irq", 32'h1, 32'(irq[0]));
    wrr(OFS_CLEAR, 32'h1FF);
    pulse(4'h2, 2);
    rdc("value0 held", OFS_VAL[0], CNT_MAX);
    chk("cnt irq held", 32'h0, 32'(irq[0]));
    $display("t_preload done");
  endtask : t_preload

  task t_mask;
    acc(1'b1, OFS_MASK, 32'h1FF, 1'b1);
    chk("ns mask resp", 32'h3, 32'(rsp));
    rdc("mask kept", OFS_MASK, 32'h1);
    wrr(OFS_AUX, 32'h08000000);
    acc(1'b1, OFS_MASK, 32'hFFFFFFFF, 1'b1);
    chk("ns mask ok", 32'h0, 32'(rsp));
    rdc("mask wide", OFS_MASK, 32'h1FF);
    // Lane 0 only, so bit 8 must survive from the old mask
    be <= 4'h1;
    wrr(OFS_MASK, 32'h0);
    be <= 4'hF;
    perr(8'hC0);
    chk("lines next level", 32'h100, 32'(irq));
    chk("combined", 32'h1, 32'(comb));
    rdc("raw", OFS_RAW, 32'h180);
    wrr(OFS_MSTAT, 32'hFFFFFFFF);
    rdc("masked", OFS_MSTAT, 32'h100);
    wrr(OFS_MASK, 32'h07E);
    perr(8'h3F);
    chk("lines ram", 32'h07E, 32'(irq));
    wrr(OFS_MASK, 32'h0);
    repeat (3) @(posedge i_clk);
    chk("combined masked", 32'h0, 32'(comb));
    $display("t_mask done");
  endtask : t_mask

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    be = 4'hF;
    ns = 1'b0;
    dbg = 1'b0;
    fire = 1'b0;
    code = 4'h0;
    sec = 16'h0000;
    err = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_codes;
    t_secure;
    t_preload;
    t_mask;
    close_out;
  end
endmodule : test_cache_event_counters_irq_mask

`default_nettype wire
